/* hdl/uwf_uart.sv */
// flow-controlled uart: transmitter, receiver, handshake and registers
//
// Notes on behaviour
// - start low, 7/8 data, parity, stop high
// - data leaves least significant bit first
// - parity none, odd, even, mark, space
// - tx active one cycle before start
// - shared pin 0 carries tx active
// - flow modes off, rts/cts, dtr/dsr, software_handshake_mode, none
// - rts/cts: start only while cts low; an xchar request starts regardless of cts
// - rts/cts: rts high when both rx stages full; other modes hold rts low
// - dtr/dsr: no send while dsr high; an xchar request is still sent
// - dtr asserted at reset, software may change
// - dtr low when connectable and accepting
// - xon resumes, xoff pauses, codes 11 and 13
// - bit period 4 to 40000 op clocks; shortest made is one core clock (4.8 op clocks)
// - straps select uart only or i2c+uart
// - uart off hands pins to gpio
// - divisor 4..40000 with eighths fraction
// - bit timing from 48 MHz operating clock
`timescale 1ns/1ns
module uwf_uart
	import uwf_pkg::*;
(
	input wire logic core_clk, // 10 MHz system clock
	input wire logic reset, // synchronous, active high
	input wire logic [3:0] reg_addr, // register word address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	input wire logic rx_line, // serial data in
	output logic tx_line, // serial data out
	output logic shared_pin_0, // tx active indicator
	input wire logic clear_to_send_n, // far end ready, low active
	output logic request_to_send_n, // we can receive, low active
	output logic terminal_ready_n, // connectable, low active
	input wire logic set_ready_n, // far end connection, low active
	input wire logic carrier_detect, // connection established
	input wire logic ring_indicator, // wake request
	input wire logic config_strap_0, // mode strap
	input wire logic config_strap_1, // mode strap
	output logic gpio_select // uart pins given to gpio
);
	// ************
	// state and registers
	// ************
	typedef enum logic [3:0]
	{
		UWF_TX_IDLE = 4'b0001,
		UWF_TX_ARM = 4'b0010,
		UWF_TX_SEND = 4'b0100,
		UWF_TX_DONE = 4'b1000
	} uwf_tx_state_t;

	typedef enum logic [2:0]
	{
		UWF_RX_IDLE = 3'b001,
		UWF_RX_START = 3'b010,
		UWF_RX_DATA = 3'b100
	} uwf_rx_state_t;

	uwf_tx_state_t tx_st_q;
	uwf_rx_state_t rx_st_q;
	logic [31:0] ctrl_q;
	logic [18:0] div_q;
	logic [7:0] tx_hold_q;
	logic tx_full_q;
	logic [7:0] rx_hold_q;
	logic rx_valid_q;
	logic rx_err_q;
	logic rx_ovr_q;
	logic rx_pend_q;
	logic [7:0] rx_pend_data_q;
	logic rx_pend_err_q;
	logic paused_q;
	logic [7:0] xchar_q;
	logic xchar_req_q;
	logic tx_is_x_q;
	logic uart_only_q;
	logic [15:0] half_q;
	logic [11:0] fr_q;

	// ************
	// decode
	// ************
	uwf_flow_t flow;
	uwf_parity_t par;
	assign flow = uwf_flow_t'(ctrl_q[UWF_CTRL_FLOW_LSB +: 3]);
	assign par = uwf_parity_t'(ctrl_q[UWF_CTRL_PAR_LSB +: 3]);
	wire logic bits8 = ctrl_q[UWF_CTRL_BITS8];
	wire logic stop2 = ctrl_q[UWF_CTRL_STOP2];
	wire logic uart_off = (flow == UWF_FLOW_OFF);
	wire logic wr_ctrl = reg_wr && reg_addr == UWF_REG_CTRL;
	wire logic wr_div = reg_wr && reg_addr == UWF_REG_DIV;
	wire logic wr_tx = reg_wr && reg_addr == UWF_REG_TXDATA;
	wire logic wr_x = reg_wr && reg_addr == UWF_REG_XCHAR;
	wire logic rd_rx = reg_rd && reg_addr == UWF_REG_RXDATA;

	// divisor clamp 4..40000 op clocks, with eighths
	wire logic [15:0] div_int = reg_wdata[UWF_DIV_FRAC_W +: 16];
	wire logic [15:0] div_clamp = (div_int < UWF_DIV_MIN) ? UWF_DIV_MIN :
		((div_int > UWF_DIV_MAX) ? UWF_DIV_MAX : div_int);
	wire logic [18:0] div_new = {div_clamp,
		reg_wdata[UWF_DIV_FRAC_W-1:0]};
	// op-clock divisor rescaled to core clocks: x10/48
	wire logic [34:0] div_scaled = 35'({div_q, 4'h0} *
		UWF_CORE_CLK_MHZ) / 35'(UWF_OP_CLK_MHZ);
	wire logic [18:0] div_core = (div_scaled[34:4] < 31'h8) ? 19'h8 :
		div_scaled[22:4];

	// ************
	// transmit path
	// ************
	wire logic tx_tick;
	wire logic tx_busy;
	wire logic [11:0] tx_bits;
	wire logic [7:0] tx_byte = xchar_req_q ? xchar_q : tx_hold_q;
	wire logic [7:0] tx_mask = bits8 ? tx_byte : {1'b0, tx_byte[6:0]};
	wire logic odd_ones = ^tx_mask;
	// parity choice
	wire logic tx_par = (par == UWF_PAR_ODD) ? ~odd_ones :
		(par == UWF_PAR_EVEN) ? odd_ones : (par == UWF_PAR_MARK);
	wire logic has_par = (par != UWF_PAR_NONE);
	wire logic [3:0] tx_len = 4'h1 + (bits8 ? 4'h8 : 4'h7) +
		{3'h0, has_par} + (stop2 ? 4'h2 : 4'h1);
	// frame: start, data lsb first, parity, stops
	wire logic [11:0] frame7 = has_par ? {3'h7, tx_par, tx_mask[6:0],
		1'b0} : {4'hf, tx_mask[6:0], 1'b0};
	wire logic [11:0] frame8 = has_par ? {2'h3, tx_par, tx_mask, 1'b0}
		: {3'h7, tx_mask, 1'b0};
	wire logic [11:0] tx_frame = bits8 ? frame8 : frame7;
	wire logic cts_ok = (flow != UWF_FLOW_RTS_CTS) ||
		!clear_to_send_n;
	wire logic dsr_ok = (flow != UWF_FLOW_DTR_DSR) ||
		!set_ready_n;
	wire logic x_ok = (flow != UWF_FLOW_SOFTWARE_HANDSHAKE_MODE) || !paused_q;
	// handshake chars ignore the pause so xon can always leave
	wire logic tx_go = !uart_off && tx_st_q == UWF_TX_IDLE &&
		(xchar_req_q || (tx_full_q && cts_ok && dsr_ok && x_ok));
	wire logic tx_load = tx_st_q == UWF_TX_ARM;

	uwf_baud #(
		.DIV_W(19)
	) u_tx_baud (
		.core_clk(core_clk),
		.reset(reset),
		.restart(tx_load),
		.step_div(div_core),
		.tick(tx_tick)
	);

	uwf_shift #(
		.W(12)
	) u_tx_shift (
		.core_clk(core_clk),
		.reset(reset),
		.load(tx_load),
		.load_bits(tx_frame),
		.load_len(tx_len),
		.step(tx_tick),
		.shift_in(1'b1),
		.bits_q(tx_bits),
		.busy_q(tx_busy)
	);

	always_ff @(posedge core_clk)
	begin
		if (reset)
			tx_st_q <= UWF_TX_IDLE;
		else
			case (tx_st_q)
				UWF_TX_IDLE: if (tx_go) tx_st_q <= UWF_TX_ARM;
				UWF_TX_ARM: tx_st_q <= UWF_TX_SEND;
				UWF_TX_SEND: if (!tx_busy) tx_st_q <= UWF_TX_DONE;
				UWF_TX_DONE: tx_st_q <= UWF_TX_IDLE;
				default: tx_st_q <= UWF_TX_IDLE;
			endcase
	end

	// ************
	// receive path
	// ************
	wire logic rx_tick;
	wire logic rx_busy;
	wire logic [11:0] rx_bits;
	logic rx_prev_q;
	wire logic rx_fall = rx_prev_q && !rx_line;
	wire logic half_done = rx_st_q == UWF_RX_START &&
		half_q >= div_core[18:4];
	wire logic rx_confirm = half_done && !rx_line;
	wire logic [3:0] rx_len = (bits8 ? 4'h8 : 4'h7) +
		{3'h0, has_par} + 4'h1;
	wire logic rx_end = rx_st_q == UWF_RX_DATA && !rx_busy;
	// align the captured frame down to bit 0
	wire logic [11:0] rx_al = rx_bits >> (4'hc - rx_len);
	wire logic [7:0] rx_data = bits8 ? rx_al[7:0] : {1'b0, rx_al[6:0]};
	wire logic rx_pbit = bits8 ? rx_al[8] : rx_al[7];
	wire logic rx_stop = has_par ? (bits8 ? rx_al[9] : rx_al[8]) :
		(bits8 ? rx_al[8] : rx_al[7]);
	wire logic rx_ones = ^rx_data;
	wire logic rx_pexp = (par == UWF_PAR_ODD) ? ~rx_ones :
		(par == UWF_PAR_EVEN) ? rx_ones : (par == UWF_PAR_MARK);
	wire logic rx_bad = (has_par && rx_pbit != rx_pexp) ||
		!rx_stop;
	wire logic in_x = flow == UWF_FLOW_SOFTWARE_HANDSHAKE_MODE &&
		(rx_data == UWF_XON_CODE || rx_data == UWF_XOFF_CODE);

	uwf_baud #(
		.DIV_W(19)
	) u_rx_baud (
		.core_clk(core_clk),
		.reset(reset),
		.restart(rx_confirm),
		.step_div(div_core),
		.tick(rx_tick)
	);

	uwf_shift #(
		.W(12)
	) u_rx_shift (
		.core_clk(core_clk),
		.reset(reset),
		.load(rx_confirm),
		.load_bits(12'hfff),
		.load_len(rx_len),
		.step(rx_tick),
		.shift_in(rx_line),
		.bits_q(rx_bits),
		.busy_q(rx_busy)
	);

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			rx_st_q <= UWF_RX_IDLE;
			rx_prev_q <= 1'b1;
			half_q <= 16'h0;
		end
		else
		begin
			rx_prev_q <= rx_line;
			half_q <= (rx_st_q == UWF_RX_START) ? half_q + 16'h1 : 16'h0;
			case (rx_st_q)
				UWF_RX_IDLE: if (rx_fall && !uart_off)
					rx_st_q <= UWF_RX_START;
				UWF_RX_START: if (half_done)
					rx_st_q <= rx_line ? UWF_RX_IDLE : UWF_RX_DATA;
				UWF_RX_DATA: if (!rx_busy) rx_st_q <= UWF_RX_IDLE;
				default: rx_st_q <= UWF_RX_IDLE;
			endcase
		end
	end

	// ************
	// receive holding and flow state
	// ************
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			rx_hold_q <= 8'h0;
			rx_valid_q <= 1'b0;
			rx_err_q <= 1'b0;
			rx_ovr_q <= 1'b0;
			rx_pend_q <= 1'b0;
			rx_pend_data_q <= 8'h0;
			rx_pend_err_q <= 1'b0;
			paused_q <= 1'b0;
		end
		else
		begin
			// clear first so a same-cycle overrun still wins
			if (wr_ctrl)
				rx_ovr_q <= 1'b0;
			if (rx_end && in_x)
				paused_q <= (rx_data == UWF_XOFF_CODE);
			else if (flow != UWF_FLOW_SOFTWARE_HANDSHAKE_MODE)
				paused_q <= 1'b0;
			if (rx_end && !in_x && rx_valid_q && !rd_rx)
			begin
				// second stage; overrun if already occupied
				if (rx_pend_q)
					rx_ovr_q <= 1'b1;
				rx_pend_q <= 1'b1;
				rx_pend_data_q <= rx_data;
				rx_pend_err_q <= rx_bad;
			end
			else if (rx_end && !in_x)
			begin
				rx_hold_q <= rx_pend_q ? rx_pend_data_q : rx_data;
				rx_err_q <= rx_pend_q ? rx_pend_err_q : rx_bad;
				rx_pend_data_q <= rx_data;
				rx_pend_err_q <= rx_bad;
				rx_valid_q <= 1'b1;
			end
			else if (rd_rx && rx_pend_q)
			begin
				rx_hold_q <= rx_pend_data_q;
				rx_err_q <= rx_pend_err_q;
				rx_pend_q <= 1'b0;
			end
			else if (rd_rx)
				rx_valid_q <= 1'b0;
		end
	end

	// ************
	// registers and control
	// ************
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			ctrl_q <= UWF_CTRL_RESET; // dtr set at reset
			div_q <= UWF_DIV_RESET;
			tx_hold_q <= 8'h0;
			tx_full_q <= 1'b0;
			xchar_q <= UWF_XON_CODE;
			xchar_req_q <= 1'b0;
			tx_is_x_q <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= reg_wdata; // dtr writable any time
			if (wr_div)
				div_q <= div_new;
			if (wr_x)
				xchar_q <= reg_wdata[7:0];
			if (tx_load)
				tx_is_x_q <= xchar_req_q;
			// load wins over a write landing on the same edge
			if (tx_load && xchar_req_q)
				xchar_req_q <= 1'b0;
			else if (wr_ctrl && reg_wdata[UWF_CTRL_SEND_XCHAR])
				xchar_req_q <= 1'b1;
			if (tx_load && !xchar_req_q)
				tx_full_q <= 1'b0;
			else if (wr_tx && !tx_full_q)
			begin
				tx_hold_q <= reg_wdata[7:0];
				tx_full_q <= 1'b1;
			end
		end
	end

	// straps resampled every cycle once reset is released
	always_ff @(posedge core_clk)
	begin
		if (reset)
			uart_only_q <= 1'b0;
		else
			uart_only_q <= config_strap_0 & ~config_strap_1;
	end

	// ************
	// read mux and pins
	// ************
	wire logic [31:0] status = {23'h0, uart_only_q, ring_indicator,
		carrier_detect, paused_q, rx_ovr_q, rx_err_q, rx_valid_q,
		tx_full_q, tx_st_q != UWF_TX_IDLE};
	wire logic [31:0] rd_mux =
		(reg_addr == UWF_REG_CTRL) ? ctrl_q :
		(reg_addr == UWF_REG_DIV) ? {13'h0, div_q} :
		(reg_addr == UWF_REG_TXDATA) ? {24'h0, tx_hold_q} :
		(reg_addr == UWF_REG_RXDATA) ? {24'h0, rx_hold_q} :
		(reg_addr == UWF_REG_STATUS) ? status :
		(reg_addr == UWF_REG_XCHAR) ? {24'h0, xchar_q} : 32'h0;
	wire logic both_full = rx_valid_q && rx_pend_q;
	wire logic tx_act = tx_st_q == UWF_TX_ARM ||
		tx_st_q == UWF_TX_SEND;

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			reg_rdata <= 32'h0;
			tx_line <= 1'b1;
			shared_pin_0 <= 1'b0;
			request_to_send_n <= 1'b1;
			terminal_ready_n <= 1'b1;
			gpio_select <= 1'b0;
		end
		else
		begin
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
			tx_line <= (tx_st_q == UWF_TX_SEND) ? tx_bits[0] : 1'b1;
			shared_pin_0 <= tx_act;
			request_to_send_n <= flow == UWF_FLOW_RTS_CTS ?
				both_full : 1'b0;
			terminal_ready_n <= !(ctrl_q[UWF_CTRL_DTR] && !uart_off &&
				!both_full);
			gpio_select <= uart_off;
		end
	end
endmodule : uwf_uart

/* hdl/uwf_pkg.sv */
// constants, register map and types for the flow-controlled uart
package uwf_pkg;

	// ************
	// register map
	// ************
	localparam logic [3:0] UWF_REG_CTRL = 4'h0;
	localparam logic [3:0] UWF_REG_DIV = 4'h1;
	localparam logic [3:0] UWF_REG_TXDATA = 4'h2;
	localparam logic [3:0] UWF_REG_RXDATA = 4'h3;
	localparam logic [3:0] UWF_REG_STATUS = 4'h4;
	localparam logic [3:0] UWF_REG_XCHAR = 4'h5;

	// ************
	// ctrl fields
	// ************
	localparam int UWF_CTRL_FLOW_LSB = 0;
	localparam int UWF_CTRL_PAR_LSB = 3;
	localparam int UWF_CTRL_BITS8 = 6;
	localparam int UWF_CTRL_STOP2 = 7;
	localparam int UWF_CTRL_DTR = 8;
	localparam int UWF_CTRL_SEND_XCHAR = 9;
	localparam logic [31:0] UWF_CTRL_RESET = 32'h0000_01c4;

	// ************
	// divisor: integer part above 3 fraction bits
	// ************
	localparam int UWF_DIV_INT_W = 16;
	localparam int UWF_DIV_FRAC_W = 3;
	localparam logic [15:0] UWF_DIV_MIN = 16'h0004;
	localparam logic [15:0] UWF_DIV_MAX = 16'h9c40;
	localparam logic [18:0] UWF_DIV_RESET = 19'h00d05;

	// ************
	// software handshake characters
	// ************
	localparam logic [7:0] UWF_XON_CODE = 8'h11;
	localparam logic [7:0] UWF_XOFF_CODE = 8'h13;

	// ************
	// status bits
	// ************
	localparam int UWF_ST_TX_BUSY = 0;
	localparam int UWF_ST_TX_FULL = 1;
	localparam int UWF_ST_RX_VALID = 2;
	localparam int UWF_ST_RX_ERR = 3;
	localparam int UWF_ST_RX_OVR = 4;
	localparam int UWF_ST_PAUSED = 5;
	localparam int UWF_ST_CD = 6;
	localparam int UWF_ST_RI = 7;
	localparam int UWF_ST_UART_ONLY = 8;

	// ************
	// clock figures
	// ************
	localparam int UWF_OP_CLK_MHZ = 48;
	localparam int UWF_CORE_CLK_MHZ = 10;

	typedef enum logic [2:0]
	{
		UWF_FLOW_OFF = 3'h0,
		UWF_FLOW_RTS_CTS = 3'h1,
		UWF_FLOW_DTR_DSR = 3'h2,
		UWF_FLOW_SOFTWARE_HANDSHAKE_MODE = 3'h3,
		UWF_FLOW_NONE = 3'h4
	} uwf_flow_t;

	typedef enum logic [2:0]
	{
		UWF_PAR_NONE = 3'h0,
		UWF_PAR_ODD = 3'h1,
		UWF_PAR_EVEN = 3'h2,
		UWF_PAR_MARK = 3'h3,
		UWF_PAR_SPACE = 3'h4
	} uwf_parity_t;

endpackage : uwf_pkg

/* hdl/uwf_baud.sv */
// fractional baud divider: one-cycle tick per bit period
`timescale 1ns/1ns
module uwf_baud
	import uwf_pkg::*;
#(
	parameter int DIV_W = 19
)
(
	input wire logic core_clk, // system clock
	input wire logic reset, // synchronous, active high
	input wire logic restart, // realign phase to zero
	input wire logic [DIV_W-1:0] step_div, // divisor in eighths, core units
	output logic tick // one pulse per bit period
);
	// accumulates in eighths of core cycles; carry every divisor
	logic [DIV_W:0] acc_q;
	logic [DIV_W:0] acc_d;
	wire logic [DIV_W:0] inc = {{(DIV_W-UWF_DIV_FRAC_W){1'b0}},
		4'h8};
	wire logic [DIV_W:0] div_ext = {1'b0, step_div};
	wire logic wrap = (acc_q + inc) >= div_ext;

	assign acc_d = restart ? '0 :
		(wrap ? acc_q + inc - div_ext : acc_q + inc);

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			acc_q <= '0;
			tick <= 1'b0;
		end
		else
		begin
			acc_q <= acc_d;
			tick <= wrap & ~restart;
		end
	end
endmodule : uwf_baud

/* hdl/uwf_shift.sv */
// one frame shift engine used for both directions
`timescale 1ns/1ns
module uwf_shift
	import uwf_pkg::*;
#(
	parameter int W = 12
)
(
	input wire logic core_clk, // system clock
	input wire logic reset, // synchronous, active high
	input wire logic load, // load a frame
	input wire logic [W-1:0] load_bits, // frame, bit 0 first
	input wire logic [3:0] load_len, // number of bits in frame
	input wire logic step, // advance one bit
	input wire logic shift_in, // bit entering at the top
	output logic [W-1:0] bits_q, // shift contents
	output logic busy_q // frame still in progress
);
	logic [3:0] left_q;

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			bits_q <= '1;
			left_q <= 4'h0;
			busy_q <= 1'b0;
		end
		else if (load)
		begin
			bits_q <= load_bits;
			left_q <= load_len;
			busy_q <= 1'b1;
		end
		else if (step && busy_q)
		begin
			bits_q <= {shift_in, bits_q[W-1:1]};
			left_q <= left_q - 4'h1;
			busy_q <= (left_q != 4'h1);
		end
	end
endmodule : uwf_shift

/* sim/uwf_monitor.sv */
// port-level checker for the flow-controlled uart
`timescale 1ns/1ns
module uwf_monitor
	import uwf_pkg::*;
(
	input wire logic core_clk, // system clock
	input wire logic reset, // synchronous, active high
	input wire logic [3:0] reg_addr, // register word address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [31:0] reg_rdata, // read data
	input wire logic rx_line, // serial in
	input wire logic tx_line, // serial out
	input wire logic shared_pin_0, // tx active
	input wire logic clear_to_send_n, // far end ready
	input wire logic request_to_send_n, // we can receive
	input wire logic terminal_ready_n, // connectable
	input wire logic set_ready_n, // far end connection
	input wire logic carrier_detect, // connection
	input wire logic ring_indicator, // wake request
	input wire logic config_strap_0, // mode strap
	input wire logic config_strap_1, // mode strap
	input wire logic gpio_select // pins to gpio
);
	// ************
	// ctrl shadow
	// ************
	logic [2:0] flow_q;
	logic dtr_q;
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			flow_q <= UWF_CTRL_RESET[2:0];
			dtr_q <= UWF_CTRL_RESET[UWF_CTRL_DTR];
		end
		else if (reg_wr && reg_addr == UWF_REG_CTRL)
		begin
			flow_q <= reg_wdata[2:0];
			dtr_q <= reg_wdata[UWF_CTRL_DTR];
		end
	end
	default clocking mon_cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	// ************
	// properties
	// ************
	AST_TX_IDLE: assert property (!shared_pin_0 |-> tx_line)
		else $error("tx line low while inactive");
	AST_ACTIVE_LEAD: assert property ($rose(shared_pin_0) |->
		tx_line ##1 (!tx_line) [*8])
		else $error("tx active not one cycle before start");
	AST_CTS_HOLD: assert property (flow_q == UWF_FLOW_RTS_CTS &&
		clear_to_send_n && $past(clear_to_send_n) &&
		$past(clear_to_send_n, 2) |-> !$rose(shared_pin_0))
		else $error("frame started while cts high");
	AST_DSR_HOLD: assert property (flow_q == UWF_FLOW_DTR_DSR &&
		set_ready_n && $past(set_ready_n) &&
		$past(set_ready_n, 2) |-> !$rose(shared_pin_0))
		else $error("frame started while dsr high");
	AST_GPIO_OFF: assert property ((flow_q == UWF_FLOW_OFF) [*3]
		|-> gpio_select)
		else $error("pins not handed to gpio");
	AST_UART_PINS: assert property ((flow_q != UWF_FLOW_OFF) [*3]
		|-> !gpio_select)
		else $error("gpio selected while uart on");
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	AST_DTR_BOOT: assert property ($past(reset) && !reset |=>
		!terminal_ready_n)
		else $error("dtr not asserted after reset");
	AST_DTR_BIT: assert property ((!dtr_q) [*3] |-> terminal_ready_n)
		else $error("dtr low with control bit clear");
	AST_RTS_OFF: assert property ((flow_q != UWF_FLOW_RTS_CTS) [*3]
		|-> !request_to_send_n)
		else $error("rts high outside rts mode");
	COV_TX: cover property ($rose(shared_pin_0));
	COV_RTS: cover property ($rose(request_to_send_n));
	COV_GPIO: cover property ($rose(gpio_select));
endmodule : uwf_monitor

/* sim/uwf_partner.sv */
// serial device model: captures tx frames, sends rx frames
`timescale 1ns/1ns
module uwf_partner
#(
	parameter int BIT = 10
)
(
	input wire logic core_clk, // system clock
	input wire logic tx_line, // frames from the uart
	output logic rx_line, // frames to the uart
	output logic [9:0] cap_q, // bits after start
	output logic [7:0] cap_cnt // frames seen
);
	// ************
	// capture and send
	// ************
	initial
	begin
		rx_line = 1'b1;
		cap_q = 10'h000;
		cap_cnt = 8'h00;
	end
	always
	begin
		@(negedge tx_line);
		repeat (BIT / 2) @(posedge core_clk);
		for (int i = 0; i < 10; i++)
		begin
			repeat (BIT) @(posedge core_clk);
			cap_q[i] = tx_line;
		end
		cap_cnt = cap_cnt + 8'h01;
	end
	task send(input logic [11:0] f, input int n);
		for (int i = 0; i < n; i++)
		begin
			rx_line <= f[i];
			repeat (BIT) @(posedge core_clk);
		end
		rx_line <= 1'b1;
	endtask : send
endmodule : uwf_partner

/* sim/testbench.sv */
// self-checking bench for the flow-controlled uart
`timescale 1ns/1ns
module testbench;
	import uwf_pkg::*;
	logic core_clk, rx_line, tx_line, pin0, rts_n, dtr_n, gpio_sel;
	logic reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic cts_n = 1'b0, dsr_n = 1'b0, cd = 1'b1, ri = 1'b0;
	logic strap0 = 1'b1, strap1 = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
	logic [11:0] f;
	logic [9:0] cap;
	logic [7:0] cnt;
	int n_mismatch = 0, check_count = 0;
	uwf_uart u_dut (.core_clk(core_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_line(rx_line),
		.tx_line(tx_line), .shared_pin_0(pin0), .clear_to_send_n(cts_n),
		.request_to_send_n(rts_n), .terminal_ready_n(dtr_n),
		.set_ready_n(dsr_n), .carrier_detect(cd), .ring_indicator(ri),
		.config_strap_0(strap0), .config_strap_1(strap1),
		.gpio_select(gpio_sel));
	uwf_partner #(.BIT(10)) u_peer (.core_clk(core_clk),
		.tx_line(tx_line), .rx_line(rx_line), .cap_q(cap), .cap_cnt(cnt));
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// ************
	// tasks
	// ************
	task end_sim();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", s, e, g);
			n_mismatch++;
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task wcap();
		logic [7:0] c;
		c = cnt;
		for (int i = 0; i < 400 && cnt === c; i++)
			@(posedge core_clk);
		if (cnt === c)
		begin
			n_mismatch++;
			end_sim();
		end
		repeat (10) @(posedge core_clk);
	endtask : wcap
	function automatic logic [11:0] frm(input logic [7:0] d, input int p,
		input logic b8);
		logic [11:0] r;
		logic [7:0] m;
		int nb;
		r = 12'hfff;
		nb = b8 ? 8 : 7;
		m = b8 ? d : {1'b0, d[6:0]};
		for (int i = 0; i < nb; i++)
			r[i] = d[i];
		if (p != 0)
			r[nb] = (p == 1) ? ~^m : (p == 2) ? ^m : (p == 3);
		return r;
	endfunction : frm
	task sendb(input logic [7:0] d, input int p, input int flip);
		f = frm(d, p, 1'b1);
		if (flip > 0)
			f[flip] = ~f[flip];
		u_peer.send({f[10:0], 1'b0}, 12);
	endtask : sendb
	// ************
	// sequence
	// ************
	initial
	begin
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		rd(UWF_REG_CTRL, v);
		chk("ctrl reset", UWF_CTRL_RESET, v);
		rd(UWF_REG_DIV, v);
		chk("div reset", 32'(UWF_DIV_RESET), v);
		rd(UWF_REG_XCHAR, v);
		chk("xchar reset", 32'(UWF_XON_CODE), v);
		rd(4'hf, v);
		chk("unmapped", 32'h0, v);
		rd(UWF_REG_STATUS, v);
		chk("status pins", 32'h0000_0140, v & 32'h0000_01c0);
		chk("dtr on", 32'h0, 32'(dtr_n));
		wr(UWF_REG_DIV, 32'h0000_0180);
		for (int p = 0; p < 6; p++)
		begin
			wr(UWF_REG_CTRL, p < 5 ? 32'h0000_0144 | 32'(p << 3) : 32'h0000_0194);
			wr(UWF_REG_TXDATA, 32'h0000_00a5);
			wcap();
			f = frm(8'ha5, p < 5 ? p : 2, p < 5);
			chk("tx frame", 32'(f[9:0]), 32'(cap));
		end
		wr(UWF_REG_CTRL, 32'h0000_0154);
		for (int j = 0; j < 3; j++)
		begin
			sendb(8'h3c, 2, j == 0 ? 0 : j + 7);
			rd(UWF_REG_STATUS, v);
			chk("rx status", {30'h0, j > 0, 1'b1}, 32'(v[3:2]));
			rd(UWF_REG_RXDATA, v);
			chk("rx data", 32'h0000_003c, v & 32'h0000_00ff);
		end
		wr(UWF_REG_CTRL, 32'h0000_0141);
		sendb(8'h01, 0, 0);
		sendb(8'h02, 0, 0);
		chk("rts full", 32'h1, 32'(rts_n));
		sendb(8'h03, 0, 0);
		rd(UWF_REG_STATUS, v);
		chk("overrun", 32'h10, v & 32'h0000_0010);
		rd(UWF_REG_RXDATA, v);
		chk("rx first", 32'h1, v & 32'h0000_00ff);
		repeat (3) @(posedge core_clk);
		chk("rts free", 32'h0, 32'(rts_n));
		rd(UWF_REG_RXDATA, v);
		for (int m = 1; m < 3; m++)
		begin
			wr(UWF_REG_CTRL, 32'h0000_0140 | m);
			cts_n <= (m == 1);
			dsr_n <= (m == 2);
			wr(UWF_REG_TXDATA, 32'h0000_0033);
			repeat (40) @(posedge core_clk);
			chk("held", 32'h0, 32'(pin0));
			cts_n <= 1'b0;
			dsr_n <= 1'b0;
			wcap();
			chk("released", 32'h33, 32'(cap[7:0]));
		end
		wr(UWF_REG_CTRL, 32'h0000_0143);
		sendb(UWF_XOFF_CODE, 0, 0);
		wr(UWF_REG_TXDATA, 32'h0000_0044);
		repeat (40) @(posedge core_clk);
		rd(UWF_REG_STATUS, v);
		chk("paused", 32'h20, v & 32'h0000_0024);
		chk("tx held full", 32'h2, v & 32'h0000_0003);
		chk("xoff hold", 32'h0, 32'(pin0));
		sendb(UWF_XON_CODE, 0, 0);
		wcap();
		chk("resumed", 32'h44, 32'(cap[7:0]));
		sendb(UWF_XOFF_CODE, 0, 0);
		wr(UWF_REG_CTRL, 32'h0000_0343);
		wcap();
		chk("xchar sent", 32'(UWF_XON_CODE), 32'(cap[7:0]));
		wr(UWF_REG_CTRL, 32'h0);
		repeat (3) @(posedge core_clk);
		chk("gpio", 32'h1, 32'(gpio_sel));
		chk("dtr off", 32'h1, 32'(dtr_n));
		end_sim();
	end
endmodule : testbench
bind uwf_uart uwf_monitor u_mon (.core_clk, .reset, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_line, .tx_line,
	.shared_pin_0, .clear_to_send_n, .request_to_send_n,
	.terminal_ready_n, .set_ready_n, .carrier_detect, .ring_indicator,
	.config_strap_0, .config_strap_1, .gpio_select);
